// ===== rtl/sep_i2c_slave.sv
// Two-wire slave front end of a small byte-organised EEPROM.
// Assumes the bus clock and data arrive as pins, oversampled by core_clk.
`default_nettype none

module sep_i2c_slave #(
   parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic scl_pin,
   input  wire logic sda_pin_in,
   output logic      sda_pin_out,
   output logic      sda_pin_oe_n,
   input  wire logic select_strap_bit0,
   input  wire logic select_strap_bit1,
   input  wire logic select_strap_bit2,
   input  wire logic write_protect,
   output logic      prog_busy
);

   // Synchroniser stages, held strap levels, transaction registers, page latches and memory port signals
   logic [2:0]                    scl_sync_reg;
   logic [2:0]                    sda_sync_reg;
   logic [1:0]                    wp_sync_reg;
   logic [2:0]                    strap_meta_reg;
   logic [2:0]                    strap_reg;
   sep_pkg::sep_state_t           state_reg;
   logic [sep_pkg::CNT_W-1:0]     cnt_reg;
   logic [7:0]                    shift_reg;
   logic [7:0]                    tx_reg;
   logic                          oe_n_reg;
   logic [7:0]                    addr_reg;
   logic [7:0]                    page_data_reg [sep_pkg::PAGE_BYTES];
   logic [7:0]                    page_valid_reg;
   logic [sep_pkg::CNT_W-1:0]     prog_idx_reg;
   logic [sep_pkg::PROG_CNT_W-1:0] prog_cnt_reg;
   logic [7:0]                    mem_rd_data;
   logic                          mem_wr_en;
   logic [7:0]                    mem_wr_addr;
   logic [7:0]                    mem_wr_data;
   // Decoded bus conditions and handshake terms
   logic                          scl_s;
   logic                          sda_s;
   logic                          scl_rise;
   logic                          scl_fall;
   logic                          start_det;
   logic                          stop_det;
   logic                          rx_state;
   logic                          byte_done;
   logic                          ack_end;
   logic                          sel_match;
   logic                          prog_go;
   logic                          prog_end;
   logic [7:0]                    addr_inc;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; stage 0 feeds stage 1 only, stage 2 is the edge history
   // Two cycles of latency are the price of keeping metastable samples out of the decode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_pin};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_pin_in};
      end
   end

   // Straps and write protect are slow levels, still synchronised
   // Open pins must be tied low outside the block; logic cannot see a floating pad
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_sync_reg    <= 2'h0;
         strap_meta_reg <= 3'h0;
         strap_reg      <= 3'h0;
      end else begin
         wp_sync_reg    <= {wp_sync_reg[0], write_protect};
         strap_meta_reg <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
         strap_reg      <= strap_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus condition decode on synchronised samples
   // Edges compare stage 1 with stage 2, so each edge is seen for one cycle only
   assign scl_s     = scl_sync_reg[1];
   assign sda_s     = sda_sync_reg[1];
   assign scl_rise  = scl_s & ~scl_sync_reg[2];
   assign scl_fall  = ~scl_s & scl_sync_reg[2];
   // Master keeps data still while clock high, so only these two edges occur there
   assign start_det = scl_s & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_s;
   assign stop_det  = scl_s & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_s;

   // Receive states take bytes from the master; the slave never drives the clock
   assign rx_state  = (state_reg == sep_pkg::ST_SEL) | (state_reg == sep_pkg::ST_ADDR) |
                      (state_reg == sep_pkg::ST_WR);
   assign byte_done = scl_fall & (cnt_reg == sep_pkg::CNT_LAST);
   assign ack_end   = scl_fall & (cnt_reg == sep_pkg::CNT_ACK);

   // Open straps are pulled to zero at the pad, so a low bit matches an open pin
   assign sel_match = (shift_reg[sep_pkg::TYPE_MSB:sep_pkg::TYPE_LSB] == sep_pkg::TYPE_CODE) &
                      (shift_reg[sep_pkg::SEL_MSB:sep_pkg::SEL_LSB] == strap_reg);

   // Cycle only if the STOP falls in the clock right after a completed ack
   // That clock's rising edge has already moved the count to one, so one is the mark;
   // a STOP later in the byte, or with no byte latched, programs nothing
   assign prog_go   = stop_det & (state_reg == sep_pkg::ST_WR) & (cnt_reg == sep_pkg::CNT_ONE) &
                      (page_valid_reg != sep_pkg::VALID_RESET) & ~wp_sync_reg[1];
   assign prog_end  = (state_reg == sep_pkg::ST_PROG) &
                      (prog_cnt_reg == sep_pkg::PROG_CNT_W'(PROG_CYCLES - 1));

   // Whole-array wrap; the mask drops the top bit on the small part
   assign addr_inc  = (addr_reg + sep_pkg::ADDR_ONE) & sep_pkg::ADDR_MASK;

   ////////////////////////////////////////////////////////////////////////////
   // Transaction state; START from anywhere but programming restarts selection
   // Conditions on the bus take priority over the byte-level progress below
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= sep_pkg::ST_IDLE;
      end else if (state_reg == sep_pkg::ST_PROG) begin
         if (prog_end) begin                                 // Bus stays deaf until here
            state_reg <= sep_pkg::ST_IDLE;
         end
      end else if (prog_go) begin
         state_reg <= sep_pkg::ST_PROG;
      end else if (stop_det) begin
         state_reg <= sep_pkg::ST_IDLE;
      end else if (start_det) begin
         state_reg <= sep_pkg::ST_SEL;
      end else begin
         unique case (state_reg)
            sep_pkg::ST_IDLE: begin
               state_reg <= sep_pkg::ST_IDLE;
            end
            sep_pkg::ST_SEL: begin
               if (byte_done && !sel_match) begin
                  state_reg <= sep_pkg::ST_IDLE;
               end else if (ack_end) begin
                  // Read skips the address byte
                  state_reg <= (shift_reg[sep_pkg::DIR_BIT] == sep_pkg::DIR_READ) ?
                               sep_pkg::ST_RD : sep_pkg::ST_ADDR;
               end
            end
            sep_pkg::ST_ADDR: begin
               if (ack_end) begin
                  state_reg <= sep_pkg::ST_WR;
               end
            end
            sep_pkg::ST_WR: begin
               state_reg <= sep_pkg::ST_WR;
            end
            sep_pkg::ST_RD: begin
               // A master ack keeps the read going; at the ninth rising clock the counter still holds eight
               if (scl_rise && cnt_reg == sep_pkg::CNT_LAST && sda_s) begin
                  state_reg <= sep_pkg::ST_IDLE;             // Master nack ends the read
               end
            end
            sep_pkg::ST_PROG: begin
               state_reg <= sep_pkg::ST_PROG;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit position within the nine-clock byte slot
   // The falling edge after the ninth clock closes the slot and clears the count
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= sep_pkg::CNT_ZERO;
      end else if (state_reg == sep_pkg::ST_PROG || start_det || stop_det) begin
         cnt_reg <= sep_pkg::CNT_ZERO;
      end else if (rx_state || state_reg == sep_pkg::ST_RD) begin
         if (scl_rise && cnt_reg < sep_pkg::CNT_ACK) begin
            cnt_reg <= cnt_reg + sep_pkg::CNT_ONE;           // Eight data clocks then the ack clock
         end else if (ack_end) begin
            cnt_reg <= sep_pkg::CNT_ZERO;
         end
      end
   end

   // Incoming bits, MSB first, taken on rising clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= sep_pkg::BYTE_RESET;
      end else if (rx_state && scl_rise && cnt_reg < sep_pkg::CNT_LAST) begin
         shift_reg <= {shift_reg[6:0], sda_s};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outgoing byte; loaded at the falling edge that closes the previous ack
   // Ones shifted in behind the data never reach the line; the release at the eighth fall comes from the enable logic
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_reg <= sep_pkg::BYTE_RESET;
      end else if (ack_end && !start_det && !stop_det &&
                   ((state_reg == sep_pkg::ST_SEL && shift_reg[sep_pkg::DIR_BIT] == sep_pkg::DIR_READ) ||
                    state_reg == sep_pkg::ST_RD)) begin
         tx_reg <= mem_rd_data;                              // Current counter location
      end else if (state_reg == sep_pkg::ST_RD && scl_fall &&
                   cnt_reg >= sep_pkg::CNT_ONE && cnt_reg < sep_pkg::CNT_LAST) begin
         tx_reg <= {tx_reg[6:0], 1'b1};
      end
   end

   // Data line enable: ack pulls, read bits drive zeros, everything else releases
   // Every change waits for a synchronised clock fall, so the line never moves while clock is high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_n_reg <= sep_pkg::OE_N_RESET;
      end else if (state_reg == sep_pkg::ST_PROG || start_det || stop_det) begin
         oe_n_reg <= sep_pkg::OE_N_RESET;
      end else if (rx_state && byte_done) begin
         // Select acked only on match and outside programming; others always
         oe_n_reg <= (state_reg == sep_pkg::ST_SEL) ? ~sel_match : 1'b0;
      end else if (ack_end) begin
         if ((state_reg == sep_pkg::ST_SEL && shift_reg[sep_pkg::DIR_BIT] == sep_pkg::DIR_READ) ||
             state_reg == sep_pkg::ST_RD) begin
            oe_n_reg <= mem_rd_data[7];                      // First bit of next byte
         end else begin
            oe_n_reg <= sep_pkg::OE_N_RESET;
         end
      end else if (state_reg == sep_pkg::ST_RD && scl_fall) begin
         // New bit only while clock is low; release at eighth fall for master ack
         oe_n_reg <= (cnt_reg < sep_pkg::CNT_LAST) ? tx_reg[6] : sep_pkg::OE_N_RESET;
      end else if (state_reg == sep_pkg::ST_IDLE) begin
         oe_n_reg <= sep_pkg::OE_N_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory address counter
   // Limitation: bytes beyond the page end overwrite the first bytes of the same page
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= sep_pkg::ADDR_RESET;
      end else if (state_reg == sep_pkg::ST_ADDR && byte_done && !start_det && !stop_det) begin
         addr_reg <= shift_reg & sep_pkg::ADDR_MASK;
      end else if (state_reg == sep_pkg::ST_WR && byte_done && !start_det && !stop_det) begin
         // Page stays fixed; low bits wrap inside the page
         addr_reg <= {addr_reg[7:sep_pkg::PAGE_W], addr_reg[sep_pkg::PAGE_W-1:0] + sep_pkg::PAGE_ONE};
      end else if (state_reg == sep_pkg::ST_RD && byte_done && !start_det && !stop_det) begin
         addr_reg <= addr_inc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page latches: eight bytes collected before programming
   // Eight registers buy a whole-page program in one cycle instead of eight
   genvar gi;
   generate
      for (gi = 0; gi < sep_pkg::PAGE_BYTES; gi = gi + 1) begin : g_page
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               page_data_reg[gi]  <= sep_pkg::BYTE_RESET;
               page_valid_reg[gi] <= 1'b0;
            end else if (state_reg == sep_pkg::ST_ADDR && byte_done) begin
               page_valid_reg[gi] <= 1'b0;                   // Dummy write leaves nothing to program
            end else if (state_reg == sep_pkg::ST_WR && byte_done && !start_det && !stop_det &&
                         addr_reg[sep_pkg::PAGE_W-1:0] == 3'(gi)) begin
               page_data_reg[gi]  <= shift_reg;              // A ninth byte overwrites the first
               page_valid_reg[gi] <= 1'b1;
            end else if (prog_end || (stop_det && !prog_go && state_reg != sep_pkg::ST_PROG)) begin
               page_valid_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Programming sequencer: copy latched bytes, then hold busy for the cycle time
   // The copy uses the first eight cycles, far inside the programming time
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_idx_reg <= sep_pkg::CNT_ZERO;
         prog_cnt_reg <= '0;
      end else if (state_reg != sep_pkg::ST_PROG) begin
         prog_idx_reg <= sep_pkg::CNT_ZERO;
         prog_cnt_reg <= '0;
      end else begin
         if (prog_idx_reg < sep_pkg::IDX_DONE) begin
            prog_idx_reg <= prog_idx_reg + sep_pkg::CNT_ONE;
         end
         prog_cnt_reg <= prog_cnt_reg + 1'b1;
      end
   end

   // Write protect also gates the copy itself, in case it rises mid-cycle
   assign mem_wr_en   = (state_reg == sep_pkg::ST_PROG) & (prog_idx_reg < sep_pkg::IDX_DONE) &
                        page_valid_reg[prog_idx_reg[sep_pkg::PAGE_W-1:0]] & ~wp_sync_reg[1];
   assign mem_wr_addr = {addr_reg[7:sep_pkg::PAGE_W], prog_idx_reg[sep_pkg::PAGE_W-1:0]};
   assign mem_wr_data = page_data_reg[prog_idx_reg[sep_pkg::PAGE_W-1:0]];

   // Read port follows the counter, so read data trail it by one cycle
   sep_mem u_mem (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (mem_wr_en),
      .wr_addr  (mem_wr_addr),
      .wr_data  (mem_wr_data),
      .rd_addr  (addr_reg),
      .rd_data  (mem_rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Open drain: only ever pull low
   // Busy is decoded from the state, so it rises one cycle after the STOP is seen
   assign sda_pin_out  = 1'b0;
   assign sda_pin_oe_n = oe_n_reg;
   assign prog_busy    = (state_reg == sep_pkg::ST_PROG);

endmodule

`default_nettype wire

// ===== rtl/sep_mem.sv
// Byte array of the EEPROM: one write port, registered read port.
// Assumes writes come only from the programming sequencer.
`default_nettype none

module sep_mem (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic [7:0]  rd_addr,
   output logic      [7:0]  rd_data
);

   logic [7:0] cells [sep_pkg::MEM_DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // Array holds no reset: contents are meant to survive
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
   end

   // Read data from a register; one cycle behind the address
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= sep_pkg::BYTE_RESET;
      end else begin
         rd_data <= cells[rd_addr];
      end
   end

endmodule

`default_nettype wire

// ===== rtl/sep_pkg.sv
// Constants, timing counts and state type for the serial EEPROM slave.
// Assumes a 25 MHz core clock; every user writes sep_pkg::name.
`default_nettype none

package sep_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Select byte layout
   localparam logic [3:0] TYPE_CODE    = 4'ha;     // Upper nibble 1010
   localparam int         TYPE_MSB     = 7;
   localparam int         TYPE_LSB     = 4;
   localparam int         SEL_MSB      = 3;
   localparam int         SEL_LSB      = 1;
   localparam int         DIR_BIT      = 0;
   localparam logic       DIR_READ     = 1'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Array and page geometry
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] ADDR_MASK    = 8'hff;    // 8'h7f for the 128-byte part
   localparam logic [7:0] ADDR_ONE     = 8'h01;
   localparam int         MEM_DEPTH    = 256;
   localparam int         PAGE_W       = 3;
   localparam int         PAGE_BYTES   = 8;
   localparam logic [2:0] PAGE_ONE     = 3'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Bit counter marks inside one byte slot
   localparam int         CNT_W        = 4;
   localparam logic [3:0] CNT_ZERO     = 4'h0;
   localparam logic [3:0] CNT_ONE      = 4'h1;
   localparam logic [3:0] CNT_LAST     = 4'h8;     // Eight data bits seen
   localparam logic [3:0] CNT_ACK      = 4'h9;     // Ninth clock high
   localparam logic [3:0] IDX_DONE     = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic       OE_N_RESET   = 1'h1;     // Line released
   localparam logic [7:0] ADDR_RESET   = 8'h00;
   localparam logic [7:0] BYTE_RESET   = 8'h00;
   localparam logic [7:0] VALID_RESET  = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Programming cycle time
   localparam int         CLK_HZ          = 25000000;
   localparam int         PROG_TIME_MS    = 10;
   localparam int         PROG_CYCLES     = PROG_TIME_MS * (CLK_HZ / 1000); // Longest time, rounds down
   localparam int         PROG_CNT_W      = 18;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEL,
      ST_ADDR,
      ST_WR,
      ST_RD,
      ST_PROG
   } sep_state_t;

endpackage

`default_nettype wire

// ===== tb/sep_i2c_master.sv
// Behavioural two-wire bus master; it alone drives the bus clock.
// Assumes the bench resolves the data wire with a pull-up and feeds it back.
`default_nettype none
module sep_i2c_master (
   input  wire logic core_clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_rel
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bus idles high
   initial begin
      scl     = 1'h1;
      sda_rel = 1'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Steps of four core cycles give 320 ns clock periods
   task hc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Also serves as repeated start from a low clock
   task start();
      sda_rel = 1'h1;
      hc(2);
      scl = 1'h1;
      hc(4);
      sda_rel = 1'h0;
      hc(4);
      scl = 1'h0;
      hc(2);
   endtask
   task stop();
      sda_rel = 1'h0;
      hc(2);
      scl = 1'h1;
      hc(4);
      sda_rel = 1'h1;
      hc(4);
   endtask
   // Eight bits out MSB first, then the ninth clock; send ff to read
   task byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
      logic [8:0] tx;
      tx = {d, ack_in};
      for (int i = 8; i >= 0; i--) begin
         sda_rel = tx[i];
         hc(2);
         scl = 1'h1;
         hc(4);
         if (i > 0) q[i-1] = sda;
         else ack_out = sda;
         scl = 1'h0;
         hc(2);
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/sep_i2c_slave_chk.sv
// Port checker for the serial EEPROM slave, bound to its top module.
// Assumes one core clock domain and an asynchronous active-low reset.
`default_nettype none
module sep_i2c_slave_chk #(
   parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl_pin,
   input wire logic sda_pin_in,
   input wire logic sda_pin_out,
   input wire logic sda_pin_oe_n,
   input wire logic write_protect,
   input wire logic prog_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned busy_cnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // Cycles spent busy; a counter because the span is too long to unroll
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) busy_cnt <= 0;
      else if (prog_busy) busy_cnt <= busy_cnt + 1;
      else busy_cnt <= 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Wire behaviour and programming cycle
   a_out_low: assert property (sda_pin_out == 1'h0) else $error("data pin not low");
   a_busy_quiet: assert property (prog_busy |-> sda_pin_oe_n) else $error("drive while busy");
   a_edge_scl_low: assert property ($changed(sda_pin_oe_n) |-> !$past(scl_pin))
      else $error("data changed with clock high");
   a_busy_at_stop: assert property ($rose(prog_busy) |-> scl_pin && sda_pin_in)
      else $error("cycle without stop");
   a_wp_blocks: assert property ($rose(prog_busy) |-> !write_protect) else $error("cycle while protected");
   a_prog_len: assert property ($fell(prog_busy) |-> busy_cnt + 1 >= PROG_CYCLES && busy_cnt <= PROG_CYCLES)
      else $error("cycle length wrong");
   a_ack_stands: assert property ($fell(sda_pin_oe_n) |=> (!sda_pin_oe_n) [*6])
      else $error("low drive too short");
   a_release_stands: assert property ($rose(sda_pin_oe_n) |=> sda_pin_oe_n [*6])
      else $error("release too short");
   c_prog: cover property ($rose(prog_busy));
   c_done: cover property ($fell(prog_busy));
   c_ack: cover property ($fell(sda_pin_oe_n));
endmodule
bind sep_i2c_slave sep_i2c_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .scl_pin(scl_pin), .sda_pin_in(sda_pin_in), .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n),
   .write_protect(write_protect), .prog_busy(prog_busy));
`default_nettype wire

// ===== tb/sep_i2c_slave_tb.sv
// Self-checking bench for the serial EEPROM slave, driven by a master model.
// Assumes the master model and the bound checker are compiled with it.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module sep_i2c_slave_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned PC = 200; // Short cycle, still longer than one poll
   logic       core_clk, rst_n, wp, scl, rel, sda, oe_n, dout, busy, ack;
   logic [2:0] strap;
   logic [7:0] q, ptr;
   logic [7:0] mem [256];
   bit         known [256];
   int         failures, n_compared, n, seed = 88525;
   assign sda = rel & (oe_n | dout); // Pull-up wired-and
   sep_i2c_master m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_rel(rel));
   sep_i2c_slave #(.PROG_CYCLES(PC)) uut (.core_clk(core_clk), .rst_n(rst_n), .scl_pin(scl),
      .sda_pin_in(sda), .sda_pin_out(dout), .sda_pin_oe_n(oe_n), .select_strap_bit0(strap[0]),
      .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]), .write_protect(wp), .prog_busy(busy));
   ////////////////////////////////////////////////////////////////////////////
   // Expected select byte and page-wrapped write address
   function logic [7:0] sel(input logic rw);
      return {4'ha, strap, rw};
   endfunction
   function logic [7:0] pg(input logic [7:0] a, input int i);
      return {a[7:3], a[2:0] + 3'(i)};
   endfunction
   task results();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Write n random bytes from a, then poll during the cycle
   task wr(input logic [7:0] a, input int n);
      logic [7:0] d;
      m.start();
      m.byte_io(sel(1'h0), 1'h1, q, ack); `CHK(ack, 1'h0)
      m.byte_io(a, 1'h1, q, ack); `CHK(ack, 1'h0)
      for (int i = 0; i < n; i++) begin // One to eight data bytes
         d = 8'($random(seed));
         m.byte_io(d, 1'h1, q, ack); `CHK(ack, 1'h0)
         if (!wp) mem[pg(a, i)] = d;
         if (!wp) known[pg(a, i)] = 1'b1;
      end
      m.stop(); `CHK(busy, n > 0 && !wp)
      if (busy === 1'h1) begin
         m.start();
         m.byte_io(sel(1'h0), 1'h1, q, ack); `CHK(ack, 1'h1)
         m.stop();
         for (int i = 0; i < PC && busy; i++) m.hc(1);
         #1 `CHK(busy, 1'h0)
      end
   endtask
   // Read n bytes from a, or from the counter when cur is set
   task rd(input logic [7:0] a, input int n, input logic cur);
      if (!cur) begin
         m.start();
         m.byte_io(sel(1'h0), 1'h1, q, ack);
         m.byte_io(a, 1'h1, q, ack);
      end
      m.start();
      m.byte_io(sel(1'h1), 1'h1, q, ack); `CHK(ack, 1'h0)
      for (int i = 0; i < n; i++) begin
         m.byte_io(8'hff, i == n - 1, q, ack);
         if (known[8'(a + i)]) `CHK(q, mem[8'(a + i)])
      end
      m.stop();
      ptr = 8'(a + n);
   endtask
   initial begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end
   // Watchdog, about five to six times the expected run
   initial begin
      #3000000;
      failures++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'h0;
      wp    = 1'h0;
      strap = 3'($random(seed));
      repeat (12) @(posedge core_clk);
      #1 rst_n = 1'h1;
      m.hc(4);
      for (int s = 0; s < 9; s++) begin
         m.start();
         m.byte_io(s < 8 ? {4'ha, 3'(s), 1'h0} : {4'h5, strap, 1'h0}, 1'h1, q, ack);
         m.stop();
         `CHK(ack, s < 8 ? 3'(s) != strap : 1'h1)
      end
      $display("test select done");
      wr(8'h5e, 3);
      rd(8'h58, 1, 1'h0);
      rd(8'h5e, 1, 1'h0);
      rd(ptr, 1, 1'h1);
      $display("test page done");
      wr(8'hff, 1);
      wr(8'h00, 1);
      rd(8'hff, 2, 1'h0);
      $display("test wrap done");
      wp = 1'h1;
      wr(8'h00, 2);
      wp = 1'h0;
      rd(8'h00, 2, 1'h0);
      $display("test protect done");
      for (int k = 0; k < 6; k++) begin
         ptr = 8'($random(seed));
         n = 1 + 3'($random(seed));
         wr(ptr, n);
         rd({ptr[7:3], 3'h0}, 8, 1'h0);
      end
      $display("test random done");
      results();
   end
endmodule
`default_nettype wire
